/* File: design/disc_cb_pkg.sv */
// Purpose: Shared constants and state codes for the disc control-block front end
// Assumes: 16-bit words, bit 0 of a word is its most significant bit in the docs
// Notes: Status positions below are hardware bit indices (doc bit n sits at 15-n)
package disc_cb_pkg;
	localparam int WORD_W = 16;
	localparam int PTR_W = 15;
	localparam int PTR_PEND_POS = 15;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	// Termination status word positions
	localparam int ST_COMPLETE_POS = 15;
	localparam int ST_SUMMARY_POS = 14;
	localparam int ST_ALT_POS = 10;
	localparam int ST_SYNC_POS = 9;
	localparam int ST_FORMAT_POS = 8;
	localparam int ST_SEEK_POS = 7;
	localparam int ST_DCRC_POS = 6;
	localparam int ST_ACRC_POS = 5;
	localparam int ST_NOID_POS = 4;
	localparam int ST_WPROT_POS = 3;
	localparam int ST_FAULT_POS = 2;
	localparam int ST_RSVD14_POS = 1;
	localparam int ST_NREADY_POS = 0;
	// Word offsets inside the control block
	localparam logic [15:0] CB_CYL_WORD = 16'h0002;
	localparam logic [15:0] CB_HEAD_WORD = 16'h0003;
	localparam logic [15:0] CB_STATUS_WORD = 16'h0007;
	// Host register map, byte addresses
	localparam logic [4:0] AV_PTR_OUT = 5'h00;
	localparam logic [4:0] AV_PTR_IN = 5'h04;
	localparam logic [4:0] AV_CONFIG = 5'h08;
	localparam logic [4:0] AV_STATUS = 5'h0C;
	localparam logic [4:0] AV_MEM_ADDR = 5'h10;
	localparam logic [4:0] AV_MEM_DATA = 5'h14;
	localparam logic [4:0] AV_MEM_COUNT = 5'h18;
	localparam int CFG_IRQ_EN_POS = 0;
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b000,
		DEV_BUSY = 3'b001,
		DEV_WR_CYL = 3'b010,
		DEV_WR_HEAD = 3'b011,
		DEV_WR_STAT = 3'b100,
		DEV_DONE = 3'b101
	} dev_state_t;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_IO = 2'b01,
		HOST_ACK = 2'b10
	} host_state_t;
endpackage : disc_cb_pkg

/* File: design/disc_link_if.sv */
// Purpose: Link between processor side and disc controller front end
// Assumes: Both ends share REF_CLK; no clocking block
// Notes: io_* carries the pointer instructions, mem_* the controller's memory writes
`timescale 1ns/1ps
interface disc_link_if;
	logic io_valid;
	logic io_write;
	logic [15:0] io_wdata;
	logic io_ready;
	logic [15:0] io_rdata;
	logic mem_valid;
	logic [15:0] mem_addr;
	logic [15:0] mem_data;
	logic mem_ready;
	logic irq_enable;
	logic irq;
	modport device (
		input io_valid, io_write, io_wdata, mem_ready, irq_enable,
		output io_ready, io_rdata, mem_valid, mem_addr, mem_data, irq
	);
	modport host (
		output io_valid, io_write, io_wdata, mem_ready, irq_enable,
		input io_ready, io_rdata, mem_valid, mem_addr, mem_data, irq
	);
endinterface : disc_link_if

/* File: design/disc_cb_host.sv */
// Purpose: Processor end: Avalon-MM registers turned into pointer instructions
// Assumes: Memory writes from the controller are always accepted
// Notes: Pointer accesses stall the bus until the controller has answered
`timescale 1ns/1ps
module disc_cb_host (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Avalon-MM slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Link
	disc_link_if.host LINK
);
	typedef struct packed {
		disc_cb_pkg::host_state_t state;
		logic io_valid;
		logic io_write;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] ptr_out;
		logic irq_en;
		logic [15:0] mem_addr;
		logic [15:0] mem_data;
		logic [15:0] mem_count;
	} host_reg_t;
	host_reg_t s_reg;
	host_reg_t s_next;
	logic req_io;

	assign req_io = (AVS_READ && AVS_ADDRESS == disc_cb_pkg::AV_PTR_IN)
		|| (AVS_WRITE && AVS_ADDRESS == disc_cb_pkg::AV_PTR_OUT);
	assign AVS_WAITREQUEST = req_io && s_reg.state != disc_cb_pkg::HOST_ACK;
	assign LINK.io_valid = s_reg.io_valid;
	assign LINK.io_write = s_reg.io_write;
	assign LINK.io_wdata = s_reg.wdata;
	assign LINK.mem_ready = 1'b1;
	assign LINK.irq_enable = s_reg.irq_en;

	always_comb
	begin
		s_next = s_reg;
		unique case (s_reg.state)
			disc_cb_pkg::HOST_IDLE:
				if (req_io)
				begin
					s_next.state = disc_cb_pkg::HOST_IO;
					s_next.io_valid = 1'b1;
					s_next.io_write = AVS_WRITE;
					// Start address is 15 bits; top bit always sent as zero
					s_next.wdata = {1'b0, AVS_WRITEDATA[14:0]};
					if (AVS_WRITE)
						s_next.ptr_out = {1'b0, AVS_WRITEDATA[14:0]};
				end
			disc_cb_pkg::HOST_IO:
				if (LINK.io_ready)
				begin
					s_next.io_valid = 1'b0;
					s_next.rdata = LINK.io_rdata;
					s_next.state = disc_cb_pkg::HOST_ACK;
				end
			disc_cb_pkg::HOST_ACK:
				s_next.state = disc_cb_pkg::HOST_IDLE;
			default:
				s_next.state = disc_cb_pkg::HOST_IDLE;
		endcase
		if (AVS_WRITE && AVS_ADDRESS == disc_cb_pkg::AV_CONFIG)
			s_next.irq_en = AVS_WRITEDATA[disc_cb_pkg::CFG_IRQ_EN_POS];
		if (LINK.mem_valid)
		begin
			s_next.mem_addr = LINK.mem_addr;
			s_next.mem_data = LINK.mem_data;
			s_next.mem_count = s_reg.mem_count + 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// Read mux over registered state; unmapped offsets read zero
	always_comb
	begin
		AVS_READDATA = 32'h00000000;
		unique case (AVS_ADDRESS)
			disc_cb_pkg::AV_PTR_OUT: AVS_READDATA = {16'h0000, s_reg.ptr_out};
			disc_cb_pkg::AV_PTR_IN: AVS_READDATA = {16'h0000, s_reg.rdata};
			disc_cb_pkg::AV_CONFIG: AVS_READDATA = {31'h00000000, s_reg.irq_en};
			disc_cb_pkg::AV_STATUS: AVS_READDATA = {30'h00000000, s_reg.io_valid, LINK.irq};
			disc_cb_pkg::AV_MEM_ADDR: AVS_READDATA = {16'h0000, s_reg.mem_addr};
			disc_cb_pkg::AV_MEM_DATA: AVS_READDATA = {16'h0000, s_reg.mem_data};
			disc_cb_pkg::AV_MEM_COUNT: AVS_READDATA = {16'h0000, s_reg.mem_count};
			default: AVS_READDATA = 32'h00000000;
		endcase
	end
endmodule : disc_cb_host

/* File: design/disc_cb_device.sv */
// Purpose: Disc controller front end: control-block pointer and termination status
// Assumes: Sequencer signals share REF_CLK; drive status pins are asynchronous
// Notes: Sequencing of the disc itself lives outside; it reports one OP_DONE per start
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module disc_cb_device (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Link to processor and memory
	disc_link_if.device LINK,
	// Sequencer handshake
	output logic OP_START,
	output logic [14:0] OP_POINTER,
	input wire logic OP_DONE,
	input wire logic OP_VERIFY,
	input wire logic OP_WRITES,
	input wire logic [15:0] OP_NEXT_CYL,
	input wire logic [15:0] OP_NEXT_HEAD,
	// Error reports from the sequencer
	input wire logic OP_SYNC_ERR,
	input wire logic OP_FORMAT_ERR,
	input wire logic OP_DATA_CRC_ERR,
	input wire logic OP_ADDR_CRC_ERR,
	input wire logic OP_NO_ID_ERR,
	// Drive status pins
	input wire logic DRIVE_SEEK_ERR,
	input wire logic DRIVE_FAULT,
	input wire logic DRIVE_WPROT,
	input wire logic DRIVE_READY,
	// Processor interrupt request
	output logic IRQ
);
	localparam int DRV_W = 4;

	typedef struct packed {
		disc_cb_pkg::dev_state_t state;
		logic pend;
		logic [14:0] ptr;
		logic start;
		logic mem_valid;
		logic [15:0] mem_addr;
		logic [15:0] mem_data;
		logic [15:0] status;
		logic [15:0] next_head;
		logic [DRV_W-1:0] drv_meta;
		logic [DRV_W-1:0] drv_sync;
	} dev_reg_t;

	dev_reg_t s_reg;
	dev_reg_t s_next;
	logic io_wr;
	logic [14:0] wr_ptr;
	logic alt_track;
	logic wprot_err;
	logic not_ready;
	logic [15:0] status_build;
	logic [15:0] addr_cyl;
	logic [15:0] addr_head;
	logic [15:0] addr_stat;

	// The instruction port never stalls; the pointer is a plain register
	assign LINK.io_ready = 1'b1;
	// Idle leaves ptr and pend at zero, so the read gives zero
	assign LINK.io_rdata = {s_reg.pend, s_reg.ptr};
	assign LINK.mem_valid = s_reg.mem_valid;
	assign LINK.mem_addr = s_reg.mem_addr;
	assign LINK.mem_data = s_reg.mem_data;
	assign LINK.irq = s_reg.pend && LINK.irq_enable;
	assign IRQ = s_reg.pend && LINK.irq_enable;
	assign OP_START = s_reg.start;
	assign OP_POINTER = s_reg.ptr;

	assign io_wr = LINK.io_valid && LINK.io_write;
	// Only the low 15 bits form the address; the MSB belongs to the flag
	assign wr_ptr = LINK.io_wdata[14:0];

	assign addr_cyl = {1'b0, s_reg.ptr} + disc_cb_pkg::CB_CYL_WORD;
	assign addr_head = {1'b0, s_reg.ptr} + disc_cb_pkg::CB_HEAD_WORD;
	assign addr_stat = {1'b0, s_reg.ptr} + disc_cb_pkg::CB_STATUS_WORD;

	// Drive bits: 0 seek error, 1 fault, 2 write protect, 3 ready
	assign alt_track = OP_VERIFY && (OP_NEXT_CYL != 16'h0000);
	assign wprot_err = OP_WRITES && s_reg.drv_sync[2];
	assign not_ready = !s_reg.drv_sync[3] || s_reg.drv_sync[1];

	always_comb
	begin
		status_build = 16'h0000;
		status_build[disc_cb_pkg::ST_COMPLETE_POS] = 1'b1;
		status_build[disc_cb_pkg::ST_ALT_POS] = alt_track;
		status_build[disc_cb_pkg::ST_SYNC_POS] = OP_SYNC_ERR;
		status_build[disc_cb_pkg::ST_FORMAT_POS] = OP_FORMAT_ERR;
		status_build[disc_cb_pkg::ST_SEEK_POS] = s_reg.drv_sync[0];
		status_build[disc_cb_pkg::ST_DCRC_POS] = OP_DATA_CRC_ERR;
		status_build[disc_cb_pkg::ST_ACRC_POS] = OP_ADDR_CRC_ERR;
		status_build[disc_cb_pkg::ST_NOID_POS] = OP_NO_ID_ERR;
		status_build[disc_cb_pkg::ST_WPROT_POS] = wprot_err;
		status_build[disc_cb_pkg::ST_FAULT_POS] = s_reg.drv_sync[1];
		status_build[disc_cb_pkg::ST_RSVD14_POS] = 1'b0;
		status_build[disc_cb_pkg::ST_NREADY_POS] = not_ready;
		// Alternate track counts as an error as well
		status_build[disc_cb_pkg::ST_SUMMARY_POS] = alt_track || OP_SYNC_ERR
			|| OP_FORMAT_ERR || s_reg.drv_sync[0] || OP_DATA_CRC_ERR
			|| OP_ADDR_CRC_ERR || OP_NO_ID_ERR || wprot_err || s_reg.drv_sync[1]
			|| not_ready;
	end

	always_comb
	begin
		s_next = s_reg;
		s_next.start = 1'b0;
		// First stage feeds only the second stage
		s_next.drv_meta = {DRIVE_READY, DRIVE_WPROT, DRIVE_FAULT, DRIVE_SEEK_ERR};
		s_next.drv_sync = s_reg.drv_meta;
		unique case (s_reg.state)
			disc_cb_pkg::DEV_IDLE:
				// A zero write is no start; it leaves the block idle
				if (io_wr && wr_ptr != 15'h0000)
				begin
					s_next.state = disc_cb_pkg::DEV_BUSY;
					s_next.ptr = wr_ptr;
					s_next.start = 1'b1;
				end
			disc_cb_pkg::DEV_BUSY:
				if (OP_DONE)
				begin
					s_next.status = status_build;
					s_next.next_head = OP_NEXT_HEAD;
					s_next.mem_valid = 1'b1;
					if (alt_track)
					begin
						s_next.state = disc_cb_pkg::DEV_WR_CYL;
						s_next.mem_addr = addr_cyl;
						s_next.mem_data = OP_NEXT_CYL;
					end
					else
					begin
						s_next.state = disc_cb_pkg::DEV_WR_STAT;
						s_next.mem_addr = addr_stat;
						s_next.mem_data = status_build;
					end
				end
			disc_cb_pkg::DEV_WR_CYL:
				if (LINK.mem_ready)
				begin
					s_next.state = disc_cb_pkg::DEV_WR_HEAD;
					s_next.mem_addr = addr_head;
					s_next.mem_data = s_reg.next_head;
				end
			disc_cb_pkg::DEV_WR_HEAD:
				if (LINK.mem_ready)
				begin
					s_next.state = disc_cb_pkg::DEV_WR_STAT;
					s_next.mem_addr = addr_stat;
					s_next.mem_data = s_reg.status;
				end
			disc_cb_pkg::DEV_WR_STAT:
				// Flag rises only once the status word has been accepted
				if (LINK.mem_ready)
				begin
					s_next.mem_valid = 1'b0;
					s_next.pend = 1'b1;
					s_next.state = disc_cb_pkg::DEV_DONE;
				end
			disc_cb_pkg::DEV_DONE:
				// Only a zero write releases the block; new starts wait for it
				if (io_wr && wr_ptr == 15'h0000)
				begin
					s_next.pend = 1'b0;
					s_next.ptr = 15'h0000;
					s_next.state = disc_cb_pkg::DEV_IDLE;
				end
			default:
				s_next.state = disc_cb_pkg::DEV_IDLE;
		endcase
	end

	// Reset leaves the block idle with a zero pointer
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
endmodule : disc_cb_device

/* File: bench/disc_cb_checker.sv */
// Purpose: Link-level checks of the disc control-block front end
// Assumes: Both ends run on REF_CLK
// Notes: io_rdata carries {pending, pointer}
`timescale 1ns/1ps
module disc_cb_checker (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Link signals
	input wire logic io_valid,
	input wire logic io_write,
	input wire logic [15:0] io_wdata,
	input wire logic [15:0] io_rdata,
	input wire logic mem_valid,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_data,
	input wire logic irq_enable,
	input wire logic irq
);
	logic zero_wr;
	logic [15:0] base;
	logic [15:0] st_reg;
	logic [15:0] adr_reg;
	assign zero_wr = io_valid && io_write && (io_wdata[14:0] == 15'h0000);
	assign base = {1'b0, io_rdata[14:0]};
	// Last memory write, so the status can be judged when pending rises
	always_ff @(posedge REF_CLK or negedge NRST)
		if (!NRST)
		begin
			st_reg <= 16'h0000;
			adr_reg <= 16'h0000;
		end
		else if (mem_valid)
		begin
			st_reg <= mem_data;
			adr_reg <= mem_addr;
		end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	property p_irq; irq == (io_rdata[15] && irq_enable); endproperty
	a_irq: assert property (p_irq) else $error("irq level wrong");
	property p_order; $rose(io_rdata[15]) |-> $past(mem_valid) && adr_reg == base + 16'h0007; endproperty
	a_order: assert property (p_order) else $error("pending before status");
	property p_cmpl; $rose(io_rdata[15]) |-> st_reg[15] && !st_reg[1] && st_reg[13:11] == 3'h0; endproperty
	a_cmpl: assert property (p_cmpl) else $error("complete bit");
	property p_sum; $rose(io_rdata[15]) |-> st_reg[14] == (|st_reg[10:2] || st_reg[0]); endproperty
	a_sum: assert property (p_sum) else $error("summary bit");
	property p_clear; zero_wr && io_rdata[15] |=> io_rdata == 16'h0000; endproperty
	a_clear: assert property (p_clear) else $error("no return to idle");
	property p_start; io_valid && io_write && !zero_wr && io_rdata == 16'h0000
		|=> io_rdata == ($past(io_wdata) & 16'h7FFF); endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_hold; io_rdata[14:0] != 15'h0000 && !(zero_wr && io_rdata[15])
		|=> $stable(io_rdata[14:0]); endproperty
	a_hold: assert property (p_hold) else $error("pointer changed");
	property p_pend; io_rdata[15] && !zero_wr |=> io_rdata[15]; endproperty
	a_pend: assert property (p_pend) else $error("pending lost");
	property p_memb; mem_valid |-> io_rdata[14:0] != 15'h0000 && !io_rdata[15]; endproperty
	a_memb: assert property (p_memb) else $error("write while idle");
	property p_msb; io_valid && io_write |-> !io_wdata[15]; endproperty
	a_msb: assert property (p_msb) else $error("pointer sent with flag bit");
	property p_alt; mem_valid && mem_addr == base + 16'h0002 |=> mem_valid
		&& mem_addr == base + 16'h0003 ##1 mem_valid && mem_addr == base + 16'h0007 && mem_data[10];
	endproperty
	a_alt: assert property (p_alt) else $error("alt sequence");
	c_alt: cover property (mem_valid && mem_addr == base + 16'h0002);
	c_done: cover property ($rose(io_rdata[15]) && irq_enable);
	c_clear: cover property (zero_wr && io_rdata[15]);
endmodule : disc_cb_checker

/* File: bench/disc_control_block_status_tb.sv */
// Purpose: Random and corner regression of both ends of the disc link
// Assumes: Host register map and stalled pointer accesses of the design
// Notes: Documented status bit n is hardware bit 15-n
`timescale 1ns/1ps
module disc_control_block_status_tb;
	logic REF_CLK, NRST, a_rd, a_wr, a_wait, done, start_seen, op_start, irq_out;
	logic [4:0] a_addr;
	logic [31:0] a_wd, a_q, q;
	logic [14:0] op_ptr;
	logic [10:0] f;
	logic [15:0] ncyl, nhead, ptr, cyl_seen, head_seen, cnt;
	int err_total, total_checks;
	disc_link_if lk ();
	disc_cb_host disc_cb_host_inst (.REF_CLK(REF_CLK), .NRST(NRST), .AVS_ADDRESS(a_addr),
		.AVS_READ(a_rd), .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd), .AVS_READDATA(a_q),
		.AVS_WAITREQUEST(a_wait), .LINK(lk));
	// Error and drive inputs all come from f so random runs mix them freely
	disc_cb_device disc_cb_device_inst (.REF_CLK(REF_CLK), .NRST(NRST), .LINK(lk),
		.OP_START(op_start), .OP_POINTER(op_ptr), .OP_DONE(done), .OP_VERIFY(f[10]),
		.OP_WRITES(f[9]), .OP_NEXT_CYL(ncyl), .OP_NEXT_HEAD(nhead), .OP_SYNC_ERR(f[0]),
		.OP_FORMAT_ERR(f[1]), .OP_DATA_CRC_ERR(f[2]), .OP_ADDR_CRC_ERR(f[3]),
		.OP_NO_ID_ERR(f[4]), .DRIVE_SEEK_ERR(f[5]), .DRIVE_FAULT(f[6]), .DRIVE_WPROT(f[7]),
		.DRIVE_READY(f[8]), .IRQ(irq_out));
	disc_cb_checker disc_cb_checker_inst (.REF_CLK(REF_CLK), .NRST(NRST),
		.io_valid(lk.io_valid), .io_write(lk.io_write), .io_wdata(lk.io_wdata),
		.io_rdata(lk.io_rdata), .mem_valid(lk.mem_valid), .mem_addr(lk.mem_addr),
		.mem_data(lk.mem_data), .irq_enable(lk.irq_enable), .irq(lk.irq));
	initial
	begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK)
	begin
		if (op_start)
			start_seen <= 1'b1;
		if (lk.mem_valid && lk.mem_ready && lk.mem_addr == ptr + 16'h0002)
			cyl_seen <= lk.mem_data;
		if (lk.mem_valid && lk.mem_ready && lk.mem_addr == ptr + 16'h0003)
			head_seen <= lk.mem_data;
	end
	function logic [15:0] exp_st(input logic [10:0] v, input logic [15:0] c);
		logic [15:0] s;
		s = {3'h4, 2'h0, v[10] && c != 16'h0000, v[0], v[1], v[5], v[2], v[3], v[4],
			v[9] && v[7], v[6], 1'b0, !v[8] || v[6]};
		s[14] = |s[10:2] || s[0];
		return s;
	endfunction : exp_st
	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("[ERR] %0t got %h expected %h", $time, g, e);
			err_total++;
		end
	endtask : chk
	// Holds the request until waitrequest is seen low at a rising edge
	task av(input logic [4:0] ad, input logic w, input logic [15:0] d);
		int n;
		@(posedge REF_CLK);
		a_addr <= ad;
		a_wr <= w;
		a_rd <= !w;
		a_wd <= {16'h0000, d};
		@(posedge REF_CLK);
		for (n = 0; a_wait !== 1'b0 && n < 40; n++)
			@(posedge REF_CLK);
		q = a_q;
		a_rd <= 1'b0;
		a_wr <= 1'b0;
		if (n >= 40)
		begin
			err_total++;
			stop_test();
		end
	endtask : av
	task run_op(input int i);
		logic alt;
		f <= (i == 0) ? 11'h100 : (i < 3) ? 11'h500 : (i == 3) ? 11'h000 : 11'($urandom);
		ncyl <= (i == 1) ? 16'h0012 : (i < 4 || i[0]) ? 16'h0000 : 16'($urandom);
		nhead <= 16'($urandom);
		ptr = (i == 0) ? 16'h0001 : (i == 1) ? 16'h7FFF : {1'b0, 15'($urandom_range(1, 32767))};
		start_seen <= 1'b0;
		cyl_seen <= 16'h0000;
		head_seen <= 16'h0000;
		av(disc_cb_pkg::AV_CONFIG, 1'b1, {15'h0000, i[0]});
		av(disc_cb_pkg::AV_MEM_COUNT, 1'b0, 16'h0000);
		cnt = q[15:0];
		av(disc_cb_pkg::AV_PTR_OUT, 1'b1, ptr);
		// Busy write with the flag bit set upstream: ignored, and sent with it clear
		av(disc_cb_pkg::AV_PTR_OUT, 1'b1, ptr ^ 16'hC000);
		av(disc_cb_pkg::AV_PTR_OUT, 1'b1, 16'h0000);
		chk(start_seen, 32'h1);
		chk(op_ptr, ptr[14:0]);
		av(disc_cb_pkg::AV_PTR_IN, 1'b0, 16'h0000);
		chk(q, {17'h0, ptr[14:0]});
		done <= 1'b1;
		@(posedge REF_CLK);
		done <= 1'b0;
		for (int n = 0; n < 20 && q[15] !== 1'b1; n++)
			av(disc_cb_pkg::AV_PTR_IN, 1'b0, 16'h0000);
		chk(q, {16'h0, 1'b1, ptr[14:0]});
		if (q[15] !== 1'b1)
			stop_test();
		chk(irq_out, i[0]);
		av(disc_cb_pkg::AV_STATUS, 1'b0, 16'h0000);
		chk(q, {31'h00000000, i[0]});
		alt = f[10] && ncyl != 16'h0000;
		av(disc_cb_pkg::AV_MEM_DATA, 1'b0, 16'h0000);
		chk(q, exp_st(f, ncyl));
		av(disc_cb_pkg::AV_MEM_ADDR, 1'b0, 16'h0000);
		chk(q, ptr + 16'h0007);
		av(disc_cb_pkg::AV_MEM_COUNT, 1'b0, 16'h0000);
		chk(16'(q[15:0] - cnt), alt ? 32'h3 : 32'h1);
		chk(cyl_seen, alt ? ncyl : 16'h0000);
		chk(head_seen, alt ? nhead : 16'h0000);
		av(disc_cb_pkg::AV_PTR_OUT, 1'b1, 16'h0000);
		av(disc_cb_pkg::AV_PTR_IN, 1'b0, 16'h0000);
		chk(q, 32'h0);
		chk(irq_out, 32'h0);
		$display("test %0d finished", i);
	endtask : run_op
	// Reset while busy must drop both ends back to idle with no stale flag
	task reset_mid();
		av(disc_cb_pkg::AV_CONFIG, 1'b1, 16'h0001);
		av(disc_cb_pkg::AV_PTR_OUT, 1'b1, 16'h0100);
		NRST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		NRST <= 1'b1;
		av(disc_cb_pkg::AV_PTR_IN, 1'b0, 16'h0000);
		chk(q, 32'h0);
		chk(op_ptr, 15'h0000);
		chk(irq_out, 32'h0);
		$display("test reset finished");
	endtask : reset_mid
	initial
	begin
		NRST = 1'b0;
		a_addr = 5'h00;
		a_rd = 1'b0;
		a_wr = 1'b0;
		a_wd = 32'h0;
		done = 1'b0;
		f = 11'h000;
		ncyl = 16'h0000;
		nhead = 16'h0000;
		ptr = 16'h0000;
		start_seen = 1'b0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(56));
		repeat (8) @(posedge REF_CLK);
		NRST <= 1'b1;
		av(5'h1C, 1'b1, 16'h1234);
		av(5'h1C, 1'b0, 16'h0000);
		chk(q, 32'h0);
		for (int i = 0; i < 24; i++)
		begin
			if (i == 12)
				reset_mid();
			run_op(i);
		end
		stop_test();
	end
endmodule : disc_control_block_status_tb
